// file: mser_defs.svh
// Constants of the response selector: exception codes, function code fields, map limits.
// Assumes inclusion by bare name from the package; the modules see its macros through it.
`ifndef MSER_DEFS_SVH
`define MSER_DEFS_SVH
`define MSER_FC_MSB          7
`define MSER_EXC_FLAG        8'h80
`define MSER_EXC_ILL_FUNC    8'h01
`define MSER_EXC_ILL_ADDR    8'h02
`define MSER_EXC_ILL_VALUE   8'h03
`define MSER_EXC_DEV_FAIL    8'h04
`define MSER_EXC_ACK         8'h05
`define MSER_EXC_BUSY        8'h06
`define MSER_EXC_MEM_PARITY  8'h08
`define MSER_EXC_GW_PATH     8'h0A
`define MSER_EXC_GW_TARGET   8'h0B
`define MSER_FC_FILE_READ    8'h14
`define MSER_FC_FILE_WRITE   8'h15
`define MSER_REG_COUNT       100
`define MSER_EXC_FRAME_BYTES 3
`endif

// file: mser_frame_tx.sv
// Byte sequencer for exception frames: address, modified function, exception code.
// Assumes a downstream framer appends the check field over the bytes it was given.
`timescale 1ns/1ps
`default_nettype none
module mser_frame_tx
   import mser_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_start,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_func,
   input  wire logic [7:0] i_code,
   input  wire logic       i_ready,
   output logic            o_valid,
   output logic [7:0]      o_data,
   output logic            o_last,
   output logic            o_busy
);
   mser_tx_t r;
   mser_tx_t next_r;
   // =====================================================================
   // Sequencer
   always_comb
   begin
      next_r = r;
      case (r.st)
         MSER_IDLE:
         begin
            if (i_start)
            begin
               next_r.st   = MSER_SEND_ADDR;
               next_r.addr = i_addr;
               next_r.func = i_func;
               next_r.code = i_code;
            end
         end
         MSER_SEND_ADDR: if (i_ready) next_r.st = MSER_SEND_FUNC;
         MSER_SEND_FUNC: if (i_ready) next_r.st = MSER_SEND_CODE;
         MSER_SEND_CODE: if (i_ready) next_r.st = MSER_IDLE;
         default:        next_r.st = MSER_IDLE;
      endcase
   end
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         r <= '{st: MSER_IDLE, addr: 8'h00, func: 8'h00, code: 8'h00};
      else
         r <= next_r;
   end
   // Data comes straight from held bytes; the state register picks which one.
   always_comb
   begin
      o_valid = (r.st != MSER_IDLE);
      o_last  = (r.st == MSER_SEND_CODE);
      o_busy  = (r.st != MSER_IDLE);
      case (r.st)
         MSER_SEND_ADDR: o_data = r.addr;
         MSER_SEND_FUNC: o_data = r.func;
         MSER_SEND_CODE: o_data = r.code;
         default:        o_data = 8'h00;
      endcase
   end
   a_frame_order: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (r.st == MSER_SEND_ADDR && i_ready) |=> (r.st == MSER_SEND_FUNC && o_data[`MSER_FC_MSB]))
      else $error("Function byte must follow address with top bit set.");
endmodule // mser_frame_tx
`default_nettype wire

// file: mser_master_model.sv
// Far-side model: the byte sink of exception replies, as the polling master sees it.
// Assumes bytes arrive as address, function, code, with last on the code byte.
`timescale 1ns/1ps
`default_nettype none
module mser_master_model
(
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_slow,
   input  wire logic       i_valid,
   input  wire logic [7:0] i_data,
   input  wire logic       i_last,
   output logic            o_ready,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_func,
   output logic [7:0]      o_code,
   output logic [7:0]      o_frames
);
   // ==========================================================
   // Capture
   // Slow mode stalls every other cycle, which stretches the busy window.
   logic [1:0] pos;
   logic       tog;
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         {pos, tog, o_ready, o_addr, o_func, o_code, o_frames} <= '0;
      end
      else
      begin
         tog     <= ~tog;
         o_ready <= ~i_slow | tog;
         if (i_valid && o_ready)
         begin
            pos <= i_last ? 2'h0 : pos + 2'h1;
            if (pos == 2'h0) o_addr <= i_data;
            if (pos == 2'h1) o_func <= i_data;
            if (i_last) o_code <= i_data;
            o_frames <= o_frames + {7'h00, i_last};
         end
      end
   end
endmodule // mser_master_model
`default_nettype wire

// file: mser_pkg.sv
// Types shared by the response selector and its byte sequencer.
// Assumes the constants header sits beside it.
`default_nettype none
`include "mser_defs.svh"
package mser_pkg;
   typedef enum logic [1:0] {MSER_NONE, MSER_NORMAL, MSER_EXCEPTION} mser_kind_t;
   // One decoded query with every condition that can refuse it.
   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  func;
      logic [15:0] offset;
      logic [15:0] length;
      logic        comm_err;
      logic        func_impl;
      logic        configured;
      logic        struct_err;
      logic        exec_fail;
      logic        prog_long;
      logic        prog_busy;
      logic        mem_parity;
      logic        gw_no_path;
      logic        gw_no_target;
   } mser_query_t;
   typedef struct packed {
      mser_kind_t kind;
      logic [7:0] addr;
      logic [7:0] func;
      logic [7:0] code;
   } mser_verdict_t;
   typedef enum {MSER_IDLE, MSER_SEND_ADDR, MSER_SEND_FUNC, MSER_SEND_CODE} mser_tx_state_t;
   typedef struct packed {
      mser_tx_state_t st;
      logic [7:0]     addr;
      logic [7:0]     func;
      logic [7:0]     code;
   } mser_tx_t;
endpackage
`default_nettype wire

// file: mser_responder.sv
// Response selector: picks none, normal or exception reply for each checked query.
// Assumes the receiver has already framed the query and checked parity and checksum.
`timescale 1ns/1ps
`default_nettype none
module mser_responder
   import mser_pkg::*;
#(
   parameter int REG_COUNT = `MSER_REG_COUNT
)
(
   input  wire logic          i_clk,
   input  wire logic          i_sys_rst,
   input  wire logic          i_query_valid,
   input  wire mser_query_t   i_query,
   input  wire logic          i_tx_ready,
   output logic               o_normal_valid,
   output logic [7:0]         o_normal_addr,
   output logic [7:0]         o_normal_func,
   output logic               o_tx_valid,
   output logic [7:0]         o_tx_data,
   output logic               o_tx_last,
   output logic               o_busy,
   output logic               o_dropped
);
   // A map larger than a 16-bit offset plus length can reach would leave codes unreachable.
   if (REG_COUNT < 1 || REG_COUNT > 65536)
   begin : g_bad_reg_count
      $error("REG_COUNT must lie in 1..65536.");
   end
   typedef struct packed {
      mser_verdict_t v;
      logic          take;
      logic          dropped;
   } mser_resp_state_t;
   mser_resp_state_t r;
   mser_resp_state_t next_r;
   logic             tx_busy;
   logic [16:0]      span_end;
   logic [7:0]       code;
   logic             refuse;
   // =====================================================================
   // Exception code selection
   // The end of the span is widened by one bit so offset plus length never wraps.
   assign span_end = {1'b0, i_query.offset} + {1'b0, i_query.length};
   always_comb
   begin
      refuse = 1'b1;
      code   = 8'h00;
      if (!i_query.func_impl || !i_query.configured || i_query.func[`MSER_FC_MSB])
         code = `MSER_EXC_ILL_FUNC;
      else if (i_query.prog_busy)
         code = `MSER_EXC_BUSY;
      else if (i_query.struct_err)
         code = `MSER_EXC_ILL_VALUE;
      else if (span_end > 17'(REG_COUNT))
         code = `MSER_EXC_ILL_ADDR;
      else if (i_query.gw_no_path)
         code = `MSER_EXC_GW_PATH;
      else if (i_query.gw_no_target)
         code = `MSER_EXC_GW_TARGET;
      else if (i_query.mem_parity &&
               (i_query.func == `MSER_FC_FILE_READ || i_query.func == `MSER_FC_FILE_WRITE))
         code = `MSER_EXC_MEM_PARITY;
      else if (i_query.exec_fail)
         code = `MSER_EXC_DEV_FAIL;
      else if (i_query.prog_long)
         code = `MSER_EXC_ACK;
      else
         refuse = 1'b0;
   end
   // =====================================================================
   // Verdict register
   // A query arriving while an exception frame is still going out is dropped; the master's
   // timeout recovers it.
   always_comb
   begin
      next_r         = r;
      next_r.take    = 1'b0;
      next_r.dropped = 1'b0;
      next_r.v.kind  = MSER_NONE;
      if (i_query_valid && !tx_busy && !r.take)
      begin
         next_r.v.addr = i_query.addr;
         if (i_query.comm_err)
            next_r.v.kind = MSER_NONE;
         else if (refuse)
         begin
            next_r.v.kind = MSER_EXCEPTION;
            next_r.v.func = i_query.func | `MSER_EXC_FLAG;
            next_r.v.code = code;
            next_r.take   = 1'b1;
         end
         else
         begin
            next_r.v.kind = MSER_NORMAL;
            next_r.v.func = i_query.func;
         end
      end
      else if (i_query_valid)
         next_r.dropped = 1'b1;
   end
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         r <= '{v: '{kind: MSER_NONE, addr: 8'h00, func: 8'h00, code: 8'h00}, take: 1'b0, dropped: 1'b0};
      else
         r <= next_r;
   end
   assign o_normal_valid = (r.v.kind == MSER_NORMAL);
   assign o_normal_addr  = r.v.addr;
   assign o_normal_func  = r.v.func;
   assign o_dropped      = r.dropped;
   assign o_busy         = tx_busy | r.take;
   mser_frame_tx u_tx (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_start   (r.take),
      .i_addr    (r.v.addr),
      .i_func    (r.v.func),
      .i_code    (r.v.code),
      .i_ready   (i_tx_ready),
      .o_valid   (o_tx_valid),
      .o_data    (o_tx_data),
      .o_last    (o_tx_last),
      .o_busy    (tx_busy)
   );
   // =====================================================================
   // Checks: reply kind
   sequence s_clean_query;
      i_query_valid && !o_busy && !i_query.comm_err;
   endsequence
   a_no_reply_err: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_query_valid && i_query.comm_err) |=> (!o_normal_valid && !r.take))
      else $error("Communication error must produce no reply.");
   a_normal_echo: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and (!refuse)) |=> (o_normal_valid && o_normal_func == $past(i_query.func)))
      else $error("Normal reply must echo the function code.");
   a_normal_addr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and (!refuse)) |=> (o_normal_addr == $past(i_query.addr)))
      else $error("Normal reply must echo the slave address.");
   a_normal_msb: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_normal_valid |-> !o_normal_func[`MSER_FC_MSB])
      else $error("Normal reply function code must be below 80 hex.");
   a_exc_no_normal: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and refuse) |=> !o_normal_valid)
      else $error("Unserviceable query must not get a normal reply.");
   a_exc_taken: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and refuse) |=> (r.take && r.v.code == $past(code)))
      else $error("Unserviceable query must start an exception reply.");
   a_exc_func_plus: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and refuse) |=> (r.v.func == ($past(i_query.func) | 8'h80))
      ##1 (o_tx_valid && o_tx_data == $past(i_query.addr, 2)))
      else $error("Exception frame must carry address then function plus 80 hex.");
   a_exc_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      r.take |-> r.v.func[`MSER_FC_MSB])
      else $error("Exception function code must have its top bit set.");
   // A query that meets a busy selector is lost on purpose; only o_dropped and the master's timeout see it.
   a_drop_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_query_valid && o_busy) |=> (o_dropped && !o_normal_valid))
      else $error("Query during a pending reply must be dropped.");
   // =====================================================================
   // Checks: exception code priority
   // Each step is checked only with every stronger refusal absent, so a reordered
   // if chain trips the step that it skipped.
   sequence s_func_usable;
      i_query.func_impl && i_query.configured && !i_query.func[`MSER_FC_MSB] && !i_query.prog_busy;
   endsequence
   sequence s_span_usable;
      !i_query.struct_err && (span_end <= 17'(REG_COUNT));
   endsequence
   sequence s_route_usable;
      !i_query.gw_no_path && !i_query.gw_no_target;
   endsequence
   a_code_illfunc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and !i_query.configured) |=> (r.v.code == 8'h01))
      else $error("Unconfigured slave must give code 01.");
   a_code_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and (i_query.func_impl && i_query.configured && !i_query.func[7] && i_query.prog_busy))
      |=> (r.v.code == 8'h06))
      else $error("Busy slave must give code 06.");
   a_code_struct: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and s_func_usable and i_query.struct_err) |=> (r.v.code == 8'h03))
      else $error("Structural fault must give code 03.");
   a_addr_range: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and s_func_usable and (!i_query.struct_err && span_end > 17'(REG_COUNT)))
      |=> (r.v.code == 8'h02))
      else $error("Span beyond register count must give code 02.");
   a_code_gw_path: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and s_func_usable and s_span_usable and i_query.gw_no_path) |=> (r.v.code == 8'h0A))
      else $error("Gateway without a path must give code 0a.");
   a_code_gw_target: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and s_func_usable and s_span_usable and (!i_query.gw_no_path && i_query.gw_no_target))
      |=> (r.v.code == 8'h0B))
      else $error("Silent gateway target must give code 0b.");
   a_code_parity: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and s_func_usable and s_span_usable and s_route_usable and (i_query.mem_parity &&
       (i_query.func == `MSER_FC_FILE_READ || i_query.func == `MSER_FC_FILE_WRITE))) |=> (r.v.code == 8'h08))
      else $error("File record parity failure must give code 08.");
   a_code_dev_fail: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and s_func_usable and s_span_usable and s_route_usable and
       (!i_query.mem_parity && i_query.exec_fail)) |=> (r.v.code == 8'h04))
      else $error("Failed action must give code 04.");
   a_code_ack: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (s_clean_query and s_func_usable and s_span_usable and s_route_usable and
       (!i_query.mem_parity && !i_query.exec_fail && i_query.prog_long)) |=> (r.v.code == 8'h05))
      else $error("Long programming command must give code 05.");
   // =====================================================================
   // Checks: frame bytes
   a_frame_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      r.take |=> (o_tx_valid && o_tx_data == $past(r.v.addr)))
      else $error("Exception frame must open with the slave address.");
   // The sink may stall on any byte; the byte it will take must not move under it.
   a_tx_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_tx_valid && !i_tx_ready) |=> (o_tx_valid && $stable(o_tx_data)))
      else $error("Stalled frame byte must hold.");
   a_tx_end: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_tx_last && i_tx_ready) |=> !o_tx_valid)
      else $error("Frame must end after the code byte is taken.");
   a_last_is_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_tx_last |-> (o_tx_valid && o_tx_data == r.v.code))
      else $error("Last frame byte must be the exception code.");
endmodule // mser_responder
`default_nettype wire

// file: tb.sv
// Testbench: feeds checked queries to the response selector and judges each reply.
// Assumes the design carries its own assertions; the sink model stands downstream.
`timescale 1ns/1ps
`default_nettype none
module tb import mser_pkg::*;;
   // ==========================================================
   // Signals
   logic        i_clk, i_sys_rst, q_v, slow, nv, tv, tl, busy, drop, rdy;
   mser_query_t qd;
   logic [7:0]  na, nfn, td, fa, ff, fc, nfr;
   int          n_fail, compares;
   mser_responder u_mser_responder (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_query_valid(q_v),
      .i_query(qd), .i_tx_ready(rdy), .o_normal_valid(nv), .o_normal_addr(na), .o_normal_func(nfn),
      .o_tx_valid(tv), .o_tx_data(td), .o_tx_last(tl), .o_busy(busy), .o_dropped(drop));
   mser_master_model u_mser_master_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_slow(slow),
      .i_valid(tv), .i_data(td), .i_last(tl), .o_ready(rdy), .o_addr(fa), .o_func(ff),
      .o_code(fc), .o_frames(nfr));
   // ==========================================================
   // Tasks
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("ERROR at %0t: %s", $time, m);
      end
   endtask
   function automatic mser_query_t mkq(input logic [7:0] f, input logic [15:0] l);
      mkq = '{addr: 8'h11, func: f, offset: 16'h0060, length: l, func_impl: 1'b1,
              configured: 1'b1, default: 1'b0};
   endfunction
   task automatic run(input mser_query_t q, input int k, input logic [7:0] c);
      int n0;
      int nn;
      n0 = nfr;
      nn = 0;
      q_v <= 1'b1;
      qd  <= q;
      @(posedge i_clk);
      q_v <= 1'b0;
      // A reply window of fixed length plays the master's timeout.
      repeat (20)
      begin
         @(posedge i_clk);
         if (nv === 1'b1) nn++;
      end
      chk(nn == (k == 1), "normal reply count");
      chk(nfr - n0 == (k == 2), "exception frame count");
      if (k == 1)
      begin
         chk(na === q.addr && nfn === q.func, "normal echo");
         chk(nfn < 8'h80, "normal function top bit");
      end
      if (k == 2)
      begin
         chk(fa === q.addr, "exception address byte");
         chk(ff === (q.func | 8'h80) && ff[7] === 1'b1, "exception function");
         chk(fc === c, "exception code");
      end
      chk(busy === 1'b0, "idle after reply");
   endtask
   task automatic busy_drop();
      int          nd;
      int          n0;
      mser_query_t q;
      n0 = nfr;
      nd = 0;
      q = mkq(8'h03, 16'h0004);
      q.prog_busy = 1'b1;
      slow <= 1'b1;
      q_v  <= 1'b1;
      qd   <= q;
      @(posedge i_clk);
      q_v <= 1'b0;
      @(posedge i_clk);
      q_v <= 1'b1;
      qd  <= mkq(8'h03, 16'h0004);
      @(posedge i_clk);
      q_v <= 1'b0;
      repeat (20)
      begin
         @(posedge i_clk);
         if (drop === 1'b1) nd++;
         if (nv === 1'b1) nd = nd + 10;
      end
      chk(nd == 1, "query during busy dropped");
      chk(nfr - n0 == 1 && fc === 8'h06, "single busy frame");
      slow <= 1'b0;
   endtask
   task automatic finish_test();
      $display("Comparisons: %0d, mismatches: %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ==========================================================
   // Sequence
   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // About sixteen queries of some twenty cycles each; the limit leaves wide margin.
   initial
   begin
      repeat (2000) @(posedge i_clk);
      n_fail++;
      finish_test();
   end
   initial
   begin
      mser_query_t q;
      logic [7:0]  ec [10];
      ec = '{8'h01, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0B, 8'h02};
      i_sys_rst = 1'b1;
      q_v = 1'b0;
      slow = 1'b0;
      qd = '0;
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      run(mkq(8'h03, 16'h0004), 1, 8'h00);
      run(mkq(8'h7F, 16'h0001), 1, 8'h00);
      q = mkq(8'h04, 16'h0001);
      q.comm_err = 1'b1;
      run(q, 0, 8'h00);
      run(mkq(8'h81, 16'h0001), 2, 8'h01);
      for (int i = 0; i < 10; i++)
      begin
         q = mkq(i == 6 ? 8'h14 : 8'h03, 16'h0004);
         slow <= i[0];
         case (i)
            0: q.func_impl = 1'b0;
            1: q.configured = 1'b0;
            2: q.struct_err = 1'b1;
            3: q.exec_fail = 1'b1;
            4: q.prog_long = 1'b1;
            5: q.prog_busy = 1'b1;
            6: q.mem_parity = 1'b1;
            7: q.gw_no_path = 1'b1;
            8: q.gw_no_target = 1'b1;
            default: q.length = 16'h0005;
         endcase
         run(q, 2, ec[i]);
      end
      busy_drop();
      finish_test();
   end
endmodule // tb
`default_nettype wire
